// ==== logic/rxm_consts.svh ====
// Purpose: Named offsets, bit positions and reset values for rxm_mac_ctrl
// Assumes: Included by bare name, definitions only
// Notes: Byte addresses on the 32-bit register bus
`ifndef RXM_CONSTS_SVH
`define RXM_CONSTS_SVH

// ********************
// Register offsets
// ********************
`define RXM_OFS_RX_STATUS 8'h00
`define RXM_OFS_RX_MASK 8'h04
`define RXM_OFS_TX_MODE 8'h08
`define RXM_OFS_RX_MODE 8'h0C
`define RXM_OFS_TX_STATUS 8'h10
`define RXM_OFS_DMA_CLEAR 8'h14

// ********************
// Receive status and mask bits
// ********************
`define RXM_RECEIVED_PACKET_FLAG 7
`define RXM_RD_TIMEOUT 6
`define RXM_DMA_DONE 5
`define RXM_REMOTE 4
`define RXM_RUNT 3
`define RXM_ALIGN 2
`define RXM_CRC 1
`define RXM_RING_FULL 0

// ********************
// Receive mode bits
// ********************
`define RXM_KEEP_BAD 5
`define RXM_KEEP_RUNT 3
`define RXM_REMOTE_EN 2

// ********************
// Transmit mode and status bits
// ********************
`define RXM_TALLY_HI 7
`define RXM_TALLY_LO 4
`define RXM_HOLD_N 2
`define RXM_LOOP_N 1
`define RXM_NO_DEFER 0
`define RXM_TX_COL 2
`define RXM_TX_COL16 1

// ********************
// Reset values and constants
// ********************
`define RXM_RST_MASK 8'h00
`define RXM_RST_TX_CTRL 3'h6
`define RXM_RST_RX_MODE 8'h00
`define RXM_CTRL_TYPE 16'h0900
`define RXM_COL_MAX 5'h10
`define RXM_TX_CTRL_MASK 8'h07
`define RXM_HTRANS_NONSEQ 2'h2
`define RXM_HSIZE_WORD 3'h2

`endif

// ==== logic/rxm_pkg.sv ====
// Purpose: Types shared by the receive mask and transmit mode block
// Assumes: One clock domain
// Notes: Frame summaries arrive as one struct per frame
`default_nettype none
package rxm_pkg;

  // Summary of one received frame, valid with its end strobe
  typedef struct packed {
    logic runt;
    logic alignErr;
    logic crcErr;
    logic collision;
    logic noRoom;
    logic [15:0] typeField;
  } rxm_frame_type;

  // Transmit path events
  typedef struct packed {
    logic frameStart;
    logic collision;
  } rxm_tx_event_type;

  // Latched bus address phase
  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } rxm_bus_phase_type;

endpackage
`default_nettype wire

// ==== logic/rxm_mac_ctrl.sv ====
// Purpose: Receive interrupt mask, error monitoring modes, transmit mode
// Assumes: 40 MHz clock, inputs synchronous, AHB-Lite register slave
// Notes: Zero wait-state slave, answer always OKAY
//
// Notes on behaviour
// - Received-packet interrupt gated by mask bit 7
// - Read-timeout interrupt gated by mask bit 6
// - DMA-completion interrupt gated by mask bit 5
// - Control-type frame interrupt gated by bit 4
// - Bits 3,2,1 gate runt, align, check errors
// - Bit 0 gates ring full; mask resets zero
// - Both keep bits clear: store only clean frames
// - Keep-runt: store clean runts, set packet flag
// - Keep-errored: store errored frames, set packet flag
// - Retry tally bits 7:4 read-only, counts collisions
// - Hold bit low extends request through last cycle
// - Loopback bit active low, reset one
// - No-defer bit ignores carrier when high
// - Tally 1-15 binary; sixteen reads zero, flag
// - Status flags clear by writing one, except DMA done: write zero to DMA clear
// - Kept faulty frames need no collision seen
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`include "rxm_consts.svh"
`default_nettype none
module rxm_mac_ctrl
  import rxm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxFrameEnd,
  input wire rxm_frame_type rxFrame,
  input wire logic hostReadTimeout,
  input wire logic dmaFinishedPin,
  input wire logic dmaActive,
  input wire logic [15:0] dmaCyclesLeft,
  input wire rxm_tx_event_type txEvent,
  output logic rxStore,
  output logic rxDiscard,
  output logic dmaRequestLine,
  output logic loopbackEnable,
  output logic deferDisable,
  output logic interrupt
);

  // ********************
  // Register state
  // ********************
  logic [7:0] receiveStatusFlags;
  logic [7:0] receiveInterruptMask;
  logic [2:0] transmitCtrl;
  logic [7:0] receiveModeControl;
  logic [2:0] transmitStatusFlags;
  logic [4:0] collisionCount;
  logic [3:0] retryTally;
  logic [7:0] transmitModeControl;
  rxm_bus_phase_type dataPhase;
  logic dataPhaseValid;
  logic addrPhase;
  logic busWrite;
  logic [7:0] wByte;

  // ********************
  // Bus slave
  // ********************
  // Zero wait states: the slave never stalls, so reads need no hold logic
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && (htrans == `RXM_HTRANS_NONSEQ)
    && (hsize == `RXM_HSIZE_WORD);
  assign busWrite = dataPhaseValid && dataPhase.write;
  assign wByte = hwdata[7:0];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dataPhaseValid <= 1'b0;
      dataPhase <= '0;
    end else if (hready) begin
      dataPhaseValid <= addrPhase;
      dataPhase.write <= hwrite;
      dataPhase.addr <= haddr[7:0];
    end
  end

  // Read data is captured at the address phase edge; a read right after
  // a write to the same register sees the value before that write
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0;
    end else if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        `RXM_OFS_RX_STATUS: hrdata <= {24'h0, receiveStatusFlags};
        `RXM_OFS_RX_MASK: hrdata <= {24'h0, receiveInterruptMask};
        `RXM_OFS_TX_MODE: hrdata <= {24'h0, transmitModeControl};
        `RXM_OFS_RX_MODE: hrdata <= {24'h0, receiveModeControl};
        `RXM_OFS_TX_STATUS: hrdata <= {29'h0, transmitStatusFlags};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // ********************
  // Control registers
  // ********************
  function automatic logic hit(input logic [7:0] ofs);
    hit = busWrite && (dataPhase.addr == ofs);
  endfunction

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      receiveInterruptMask <= `RXM_RST_MASK;
    end else if (hit(`RXM_OFS_RX_MASK)) begin
      receiveInterruptMask <= wByte;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      receiveModeControl <= `RXM_RST_RX_MODE;
    end else if (hit(`RXM_OFS_RX_MODE)) begin
      receiveModeControl <= wByte;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      transmitCtrl <= `RXM_RST_TX_CTRL;
    end else if (hit(`RXM_OFS_TX_MODE)) begin
      transmitCtrl <= wByte[`RXM_HOLD_N:`RXM_NO_DEFER];
    end
  end

  assign transmitModeControl = {retryTally, 1'b0, transmitCtrl};

  assign loopbackEnable = !transmitCtrl[`RXM_LOOP_N];
  assign deferDisable = transmitCtrl[`RXM_NO_DEFER];

  // ********************
  // Receive acceptance
  // ********************
  logic keepBad;
  logic keepRunt;
  logic anyError;
  logic cleanFrame;
  logic cleanRunt;
  logic accept;
  logic storeNow;
  logic remoteHit;

  assign keepBad = receiveModeControl[`RXM_KEEP_BAD];
  assign keepRunt = receiveModeControl[`RXM_KEEP_RUNT];
  assign anyError = rxFrame.runt || rxFrame.alignErr || rxFrame.crcErr;
  assign cleanFrame = !anyError && !rxFrame.collision;
  // Keep-runt keeps a runt only if otherwise clean
  assign cleanRunt = rxFrame.runt && !rxFrame.alignErr && !rxFrame.crcErr;

  always_comb begin
    accept = cleanFrame;
    // Kept faulty frames need no collision
    if (keepRunt && cleanRunt && !rxFrame.collision) begin
      accept = 1'b1;
    end
    if (keepBad && anyError && !rxFrame.collision) begin
      accept = 1'b1;
    end
  end

  assign storeNow = rxFrameEnd && accept && !rxFrame.noRoom;
  assign remoteHit = storeNow && receiveModeControl[`RXM_REMOTE_EN]
    && (rxFrame.typeField == `RXM_CTRL_TYPE);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rxStore <= 1'b0;
      rxDiscard <= 1'b0;
    end else begin
      rxStore <= storeNow;
      rxDiscard <= rxFrameEnd && !storeNow;
    end
  end

  // ********************
  // Receive status flags
  // ********************
  logic [7:0] rxSet;
  logic [7:0] rxClear;
  logic dmaClear;

  always_comb begin
    rxSet = 8'h00;
    // Packet flag on every stored frame
    rxSet[`RXM_RECEIVED_PACKET_FLAG] = storeNow;
    rxSet[`RXM_RD_TIMEOUT] = hostReadTimeout;
    rxSet[`RXM_DMA_DONE] = dmaFinishedPin;
    rxSet[`RXM_REMOTE] = remoteHit;
    // Error flags on any faulty frame
    rxSet[`RXM_RUNT] = rxFrameEnd && rxFrame.runt;
    rxSet[`RXM_ALIGN] = rxFrameEnd && rxFrame.alignErr;
    rxSet[`RXM_CRC] = rxFrameEnd && rxFrame.crcErr;
    rxSet[`RXM_RING_FULL] = rxFrameEnd && accept && rxFrame.noRoom;
  end

  // Write one clears, except DMA bit
  assign rxClear = hit(`RXM_OFS_RX_STATUS)
    ? (wByte & ~(8'h01 << `RXM_DMA_DONE)) : 8'h00;
  // DMA completion clears only through its own register
  assign dmaClear = hit(`RXM_OFS_DMA_CLEAR) && (wByte == 8'h00);

  // Set wins over a clear in the same cycle, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gFlag
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          receiveStatusFlags[gi] <= 1'b0;
        end else if (rxSet[gi]) begin
          receiveStatusFlags[gi] <= 1'b1;
        end else if (rxClear[gi] || (gi == `RXM_DMA_DONE && dmaClear)) begin
          receiveStatusFlags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ********************
  // Interrupt
  // ********************
  // Per-bit gating
  assign interrupt = |(receiveStatusFlags & receiveInterruptMask);

  // ********************
  // DMA request
  // ********************
  logic needCycles;

  // Hold through last cycle when low
  assign needCycles = transmitCtrl[`RXM_HOLD_N]
    ? (dmaCyclesLeft > 16'h0001) : (dmaCyclesLeft != 16'h0000);
  // A finished transfer blocks further requests until cleared
  assign dmaRequestLine = dmaActive && needCycles
    && !receiveStatusFlags[`RXM_DMA_DONE];

  // ********************
  // Collision tally
  // ********************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      collisionCount <= 5'h00;
    end else if (txEvent.frameStart) begin
      collisionCount <= 5'h00;
    end else if (txEvent.collision && collisionCount != `RXM_COL_MAX) begin
      collisionCount <= collisionCount + 5'h01;
    end
  end

  // Sixteen wraps to zero in the tally
  assign retryTally = collisionCount[3:0];

  logic [2:0] txSet;
  logic [2:0] txClear;

  always_comb begin
    txSet = 3'h0;
    txSet[`RXM_TX_COL] = txEvent.collision && !txEvent.frameStart;
    txSet[`RXM_TX_COL16] = txEvent.collision && !txEvent.frameStart
      && (collisionCount == `RXM_COL_MAX - 5'h01);
  end

  assign txClear = hit(`RXM_OFS_TX_STATUS) ? wByte[2:0] : 3'h0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      transmitStatusFlags <= 3'h0;
    end else begin
      transmitStatusFlags <= txSet | (transmitStatusFlags & ~txClear);
    end
  end

endmodule
`default_nettype wire

// ==== dv/rxm_mac_props.sv ====
// Purpose: Port-level checks for rxm_mac_ctrl
// Assumes: One clock, async active-high reset
// Notes: Bound to every instance of the design
`default_nettype none
module rxm_mac_props
  import rxm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic hwrite,
  input wire logic rxFrameEnd,
  input wire rxm_frame_type rxFrame,
  input wire logic hostReadTimeout,
  input wire logic dmaFinishedPin,
  input wire logic dmaActive,
  input wire logic [15:0] dmaCyclesLeft,
  input wire logic rxStore,
  input wire logic rxDiscard,
  input wire logic dmaRequestLine,
  input wire logic loopbackEnable,
  input wire logic deferDisable,
  input wire logic interrupt
);
  // ********************
  // Properties
  // ********************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic err = rxFrame.runt | rxFrame.alignErr | rxFrame.crcErr;

  a_one_verdict:
    assert property (rxFrameEnd |=> rxStore != rxDiscard) else $error("frame verdict wrong");
  a_clean_kept:
    assert property (rxFrameEnd && !err && !rxFrame.collision && !rxFrame.noRoom |=> rxStore)
      else $error("clean frame dropped");
  a_col_dropped:
    assert property (rxFrameEnd && err && rxFrame.collision |=> rxDiscard)
      else $error("collided faulty frame kept");
  a_full_dropped:
    assert property (rxFrameEnd && rxFrame.noRoom |=> rxDiscard) else $error("frame kept when full");
  a_dma_bound:
    assert property (dmaRequestLine |-> dmaActive && dmaCyclesLeft != 16'h0000)
      else $error("request outside transfer");
  a_reset_modes:
    assert property ($fell(sys_rst) |-> !loopbackEnable && !deferDisable)
      else $error("mode pins wrong after reset");
  a_irq_cause:
    assert property ($rose(interrupt) |->
      $past(rxFrameEnd || hostReadTimeout || dmaFinishedPin) || $past(hsel && hwrite, 2))
      else $error("interrupt rose without cause");
  a_irq_clear:
    assert property ($fell(interrupt) |-> $past(hsel && hwrite, 2))
      else $error("interrupt fell without write");

  c_stored: cover property (rxStore);
  c_irq: cover property ($rose(interrupt));
  c_dma: cover property (dmaRequestLine);
endmodule

bind rxm_mac_ctrl rxm_mac_props chk (.clock, .sys_rst, .hsel, .hwrite, .rxFrameEnd, .rxFrame,
  .hostReadTimeout, .dmaFinishedPin, .dmaActive, .dmaCyclesLeft, .rxStore, .rxDiscard,
  .dmaRequestLine, .loopbackEnable, .deferDisable, .interrupt);
`default_nettype wire

// ==== dv/rxm_net_model.sv ====
// Purpose: Network and pin side feeding rxm_mac_ctrl
// Assumes: Driven just after rising edges
// Notes: Pulses last one cycle
`default_nettype none
module rxm_net_model
  import rxm_pkg::*;
(
  input wire logic clock,
  output var logic rxFrameEnd = 1'b0,
  output var rxm_frame_type rxFrame = '0,
  output var rxm_tx_event_type txEvent = '0,
  output var logic hostReadTimeout = 1'b0,
  output var logic dmaFinishedPin = 1'b0
);
  // ********************
  // Drivers
  // ********************
  task automatic frame(input rxm_frame_type f);
    @(posedge clock);
    rxFrameEnd <= 1'b1;
    rxFrame <= f;
    @(posedge clock);
    rxFrameEnd <= 1'b0;
    // Stale summary would hide a late sample
    rxFrame <= ~f;
  endtask

  // Bits: read timeout, dma done, frame start, collision
  task automatic pulse(input logic [3:0] p);
    @(posedge clock);
    {hostReadTimeout, dmaFinishedPin, txEvent} <= p;
    @(posedge clock);
    {hostReadTimeout, dmaFinishedPin, txEvent} <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for rxm_mac_ctrl
// Assumes: Zero wait-state slave, fixed seed
// Notes: Expectations come from bench functions
`include "rxm_consts.svh"
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb import rxm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic dmaActive = 1'b0, rxFrameEnd, hostReadTimeout, dmaFinishedPin, rxStore, rxDiscard;
  logic dmaRequestLine, loopbackEnable, deferDisable, interrupt;
  logic [15:0] dmaCyclesLeft = 16'h0000;
  logic [7:0] m;
  rxm_frame_type rxFrame, f;
  rxm_tx_event_type txEvent;
  int miscompares = 0, samples_checked = 0, seed = 1;
  int nl[4] = '{0, 16, 1, 15};
  assign hready = hreadyout;
  always #12.5 clock = ~clock;

  rxm_mac_ctrl uut (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(`RXM_HSIZE_WORD),
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .rxFrameEnd, .rxFrame, .hostReadTimeout,
    .dmaFinishedPin, .dmaActive, .dmaCyclesLeft, .txEvent, .rxStore, .rxDiscard,
    .dmaRequestLine, .loopbackEnable, .deferDisable, .interrupt);
  rxm_net_model net (.clock, .rxFrameEnd, .rxFrame, .txEvent, .hostReadTimeout,
    .dmaFinishedPin);

  // ********************
  // Helpers
  // ********************
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= `RXM_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic dq(input logic [15:0] c, input logic e);
    @(posedge clock);
    dmaCyclesLeft <= c;
    #1 `CHK(dmaRequestLine, e)
  endtask

  function automatic logic kept(logic [7:0] md, rxm_frame_type x);
    logic e;
    e = x.runt | x.alignErr | x.crcErr;
    return !x.noRoom && (!e || !x.collision && (md[5] || md[3] && x.runt && !x.alignErr
      && !x.crcErr));
  endfunction

  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    #1000000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    bus(0, 8'h04, 8'h00);
    `CHK(r, 32'h0)
    bus(0, 8'h08, 8'h00);
    `CHK(r, 32'h6)
    `CHK({loopbackEnable, deferDisable}, 2'b00)
    m = 8'($random(seed));
    bus(1, 8'h04, m);
    bus(0, 8'h04, 8'h00);
    `CHK(r, {24'h0, m})
    bus(1, 8'h40, 8'hFF);
    bus(0, 8'h40, 8'h00);
    `CHK({hresp, r}, 33'h0)
    // Keep modes drawn from the four table rows
    repeat (40) begin
      m = 8'(($random(seed) & 5) * 8);
      bus(1, 8'h0C, m);
      f = 21'($random(seed));
      f.collision &= f.runt | f.alignErr | f.crcErr;
      net.frame(f);
      #1 `CHK(rxStore, kept(m, f))
      `CHK(rxDiscard, !kept(m, f))
    end
    bus(1, 8'h00, 8'hFF);
    bus(1, 8'h14, 8'h00);
    bus(1, 8'h0C, 8'h04);
    for (int b = 7; b >= 0; b--) begin
      bus(1, 8'h04, 8'h00);
      f = {b == 3, b == 2, b == 1, 1'b0, b == 0, (b == 4) ? 16'h0900 : 16'h0800};
      if (b == 6 || b == 5) net.pulse({b == 6, b == 5, 2'b00});
      else net.frame(f);
      #1 `CHK(interrupt, 1'b0)
      bus(0, 8'h00, 8'h00);
      `CHK(r[4], b == 4)
      bus(1, 8'h04, 8'(1 << b));
      bus(1, 8'h00, 8'h00);
      #1 `CHK(interrupt, 1'b1)
      bus(1, (b == 5) ? 8'h14 : 8'h00, (b == 5) ? 8'h00 : 8'(1 << b));
      #1 `CHK(interrupt, 1'b0)
    end
    @(posedge clock);
    dmaActive <= 1'b1;
    dq(16'h0001, 1'b0);
    dq(16'h0002, 1'b1);
    bus(1, 8'h08, 8'h02);
    dq(16'h0001, 1'b1);
    net.pulse(4'b0100);
    dq(16'h0002, 1'b0);
    bus(1, 8'h14, 8'h00);
    dmaActive <= 1'b0;
    bus(1, 8'h08, 8'hF6);
    foreach (nl[i]) begin
      net.pulse(4'b0010);
      repeat (nl[i]) net.pulse(4'b0001);
      bus(0, 8'h08, 8'h00);
      `CHK(r[7:0], {nl[i][3:0], 4'h6})
      bus(0, 8'h10, 8'h00);
      `CHK(r[2:1], {nl[i] != 0, nl[i] == 16})
      bus(1, 8'h10, 8'hFF);
    end
    bus(1, 8'h08, 8'h05);
    bus(0, 8'h08, 8'h00);
    `CHK(r[7:0], 8'hF5)
    `CHK({loopbackEnable, deferDisable}, 2'b11)
    sys_rst <= 1'b1;
    @(posedge clock);
    #1 `CHK({loopbackEnable, deferDisable}, 2'b00)
    @(posedge clock);
    sys_rst <= 1'b0;
    bus(0, 8'h04, 8'h00);
    `CHK(r, 32'h0)
    repeat (3) @(posedge clock);
    close_out();
  end
endmodule
`default_nettype wire
